// ==== core/dat_defines.svh ====
// Offsets, field positions, reset values and write masks of the analog trim registers.
// Assumes a 16-bit register word and an 8-bit register address from the serial port.
`ifndef DAT_DEFINES_SVH
`define DAT_DEFINES_SVH

// Register offsets
`define DAT_REFTRIM_OFS 8'h03
`define DAT_GAIN_OFS 8'h07
`define DAT_SPAN_OFS 8'h08
`define DAT_RSET_OFS 8'h0c

// Reset values
`define DAT_REFTRIM_RST 16'h0000
`define DAT_GAIN_RST 16'h0000
`define DAT_SPAN_RST 16'h0000
`define DAT_RSET_RST 16'h000a
`define DAT_CAL_GAIN_RST 7'h00
`define DAT_CAL_RSET_RST 5'h00

// Writable bits, reserved read-write bits included
`define DAT_REFTRIM_WMASK 16'hffff
`define DAT_GAIN_WMASK 16'h80ff
`define DAT_SPAN_WMASK 16'hffff
`define DAT_RSET_WMASK 16'he0ff

// Field positions
`define DAT_REFTRIM_MSB 5
`define DAT_REFTRIM_LSB 0
`define DAT_GAIN_CAL_MSB 14
`define DAT_GAIN_CAL_LSB 8
`define DAT_GAIN_MSB 6
`define DAT_GAIN_LSB 0
`define DAT_SPAN_MSB 1
`define DAT_SPAN_LSB 0
`define DAT_RSET_EN_BIT 15
`define DAT_RSET_CAL_MSB 12
`define DAT_RSET_CAL_LSB 8
`define DAT_RSET_MSB 4
`define DAT_RSET_LSB 0

`endif

// ==== core/dat_pkg.sv ====
// Types shared by the analog trim register bank.
// Assumes the constants of dat_defines.svh.
package dat_pkg;
   typedef logic [15:0] dat_word_type;
   typedef logic [7:0] dat_addr_type;
   typedef logic [5:0] dat_ref_trim_type;
   typedef logic signed [6:0] dat_gain_type;
   typedef logic [1:0] dat_span_type;
   typedef logic [4:0] dat_rset_type;
endpackage

// ==== core/dat_word_reg.sv ====
// One 16-bit trim register word with a reset value and a mask of writable bits.
// Assumes a single-cycle write strobe from the register port.
`timescale 1ns/100ps
module dat_word_reg #(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hffff
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire dat_pkg::dat_word_type wdata,
   output dat_pkg::dat_word_type value
);
   import dat_pkg::*;

   dat_word_type word_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= RESET_VAL;
      end else if (wr_en) begin
         word_q <= (wdata & WRITE_MASK) | (word_q & ~WRITE_MASK);
      end
   end

   assign value = word_q;
endmodule

// ==== core/dat_trim_regs.sv ====
// Analog trim register bank: reference trim, fine gain, gain span, full-scale resistor.
// Assumes the serial port presents decoded single-cycle register reads and writes,
// and the calibration engine presents its results with a load strobe.
//
// Function
// - 6-bit read-write reference trim, reset zero; 0x20 highest, 0x1F lowest.
// - Calibrated gain readable, read-only, bits 14:8 of gain register, zero at reset.
// - Signed 7-bit fine gain, reset zero, applied only outside calibration mode.
// - 2-bit gain span selector, reset zero, quarter to full adjustment span.
// - Resistor enable written at bit 15; read reports enable during calibration mode.
// - Calibrated resistor code readable, read-only, bits 12:8, zero at reset.
// - 5-bit resistor code at bits 4:0, reset 0x0A, 800 ohms per step.
// - Calibration enable chooses calibrated results over manual gain and resistor settings.
`timescale 1ns/100ps
`include "dat_defines.svh"
module dat_trim_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire dat_pkg::dat_addr_type reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire dat_pkg::dat_word_type reg_wdata,
   output dat_pkg::dat_word_type reg_rdata,
   input wire logic cal_mode_en,
   input wire logic cal_result_load,
   input wire logic cal_result_clear,
   input wire dat_pkg::dat_gain_type cal_gain_value,
   input wire dat_pkg::dat_rset_type cal_rset_value,
   output dat_pkg::dat_ref_trim_type reference_trim_code,
   output dat_pkg::dat_gain_type applied_fine_gain,
   output dat_pkg::dat_span_type gain_span_select,
   output logic internal_resistor_enable,
   output dat_pkg::dat_rset_type full_scale_resistor_code
);
   import dat_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register words

   dat_word_type reftrim_word;
   dat_word_type gain_word;
   dat_word_type span_word;
   dat_word_type rset_word;
   logic wr_reftrim;
   logic wr_gain;
   logic wr_span;
   logic wr_rset;

   assign wr_reftrim = reg_wr_en && (reg_addr == `DAT_REFTRIM_OFS);
   assign wr_gain = reg_wr_en && (reg_addr == `DAT_GAIN_OFS);
   assign wr_span = reg_wr_en && (reg_addr == `DAT_SPAN_OFS);
   assign wr_rset = reg_wr_en && (reg_addr == `DAT_RSET_OFS);

   // Reference trim word
   dat_word_reg #(.RESET_VAL(`DAT_REFTRIM_RST), .WRITE_MASK(`DAT_REFTRIM_WMASK)) u_reftrim (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_reftrim),
      .wdata(reg_wdata),
      .value(reftrim_word)
   );

   // Gain word, calibrated field masked off
   dat_word_reg #(.RESET_VAL(`DAT_GAIN_RST), .WRITE_MASK(`DAT_GAIN_WMASK)) u_gain (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_gain),
      .wdata(reg_wdata),
      .value(gain_word)
   );

   // Span word
   dat_word_reg #(.RESET_VAL(`DAT_SPAN_RST), .WRITE_MASK(`DAT_SPAN_WMASK)) u_span (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_span),
      .wdata(reg_wdata),
      .value(span_word)
   );

   // Resistor word, calibrated field masked off
   dat_word_reg #(.RESET_VAL(`DAT_RSET_RST), .WRITE_MASK(`DAT_RSET_WMASK)) u_rset (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_rset),
      .wdata(reg_wdata),
      .value(rset_word)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Calibration results

   dat_gain_type gain_cal_q;
   dat_rset_type rset_cal_q;

   // Load wins over clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gain_cal_q <= `DAT_CAL_GAIN_RST;
         rset_cal_q <= `DAT_CAL_RSET_RST;
      end else if (cal_result_load) begin
         gain_cal_q <= cal_gain_value;
         rset_cal_q <= cal_rset_value;
      end else if (cal_result_clear) begin
         gain_cal_q <= `DAT_CAL_GAIN_RST;
         rset_cal_q <= `DAT_CAL_RSET_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Analog control outputs

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reference_trim_code <= '0;
         gain_span_select <= '0;
      end else begin
         reference_trim_code <= reftrim_word[`DAT_REFTRIM_MSB:`DAT_REFTRIM_LSB];
         gain_span_select <= span_word[`DAT_SPAN_MSB:`DAT_SPAN_LSB];
      end
   end

   // Manual or calibrated settings
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         applied_fine_gain <= '0;
         full_scale_resistor_code <= 5'(`DAT_RSET_RST);
         internal_resistor_enable <= 1'b0;
      end else if (cal_mode_en) begin
         applied_fine_gain <= gain_cal_q;
         full_scale_resistor_code <= rset_cal_q;
         internal_resistor_enable <= 1'b1;
      end else begin
         applied_fine_gain <= gain_word[`DAT_GAIN_MSB:`DAT_GAIN_LSB];
         full_scale_resistor_code <= rset_word[`DAT_RSET_MSB:`DAT_RSET_LSB];
         internal_resistor_enable <= rset_word[`DAT_RSET_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read back

   dat_word_type rd_d;

   always_comb begin
      rd_d = '0;
      unique case (reg_addr)
         `DAT_REFTRIM_OFS: begin
            rd_d = reftrim_word;
         end
         `DAT_GAIN_OFS: begin
            rd_d = gain_word;
            rd_d[`DAT_GAIN_CAL_MSB:`DAT_GAIN_CAL_LSB] = gain_cal_q;
         end
         `DAT_SPAN_OFS: begin
            rd_d = span_word;
         end
         `DAT_RSET_OFS: begin
            rd_d = rset_word;
            rd_d[`DAT_RSET_CAL_MSB:`DAT_RSET_CAL_LSB] = rset_cal_q;
            rd_d[`DAT_RSET_EN_BIT] = cal_mode_en;
         end
         default: begin
            rd_d = '0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd_en) begin
         reg_rdata <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   ref_trim_write_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      wr_reftrim |=> ##1 reference_trim_code == $past(reg_wdata[5:0], 2)
   ) else $error("reference trim does not follow write");

   gain_cal_ro_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (wr_gain && !cal_result_load && !cal_result_clear) |=> gain_cal_q == $past(gain_cal_q)
   ) else $error("calibrated gain changed by write");

   gain_manual_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (wr_gain && !cal_mode_en) ##1 (!cal_mode_en && !wr_gain)
      |=> applied_fine_gain == $past(reg_wdata[6:0], 2)
   ) else $error("manual gain not applied");

   span_write_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      wr_span |=> ##1 gain_span_select == $past(reg_wdata[1:0], 2)
   ) else $error("span select does not follow write");

   rset_en_read_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (reg_rd_en && reg_addr == `DAT_RSET_OFS) |=> reg_rdata[15] == $past(cal_mode_en)
   ) else $error("resistor enable read wrong");

   rset_cal_load_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      cal_result_load ##1 (!cal_result_load && !cal_result_clear)
      |=> rset_cal_q == $past(cal_rset_value, 2)
   ) else $error("calibrated resistor not held");

   rset_manual_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (wr_rset && !cal_mode_en) ##1 (!cal_mode_en && !wr_rset)
      |=> full_scale_resistor_code == $past(reg_wdata[4:0], 2)
   ) else $error("manual resistor code not applied");

   cal_select_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      cal_mode_en [*2] |-> applied_fine_gain == $past(gain_cal_q)
         && full_scale_resistor_code == $past(rset_cal_q) && internal_resistor_enable
   ) else $error("calibrated settings not selected");

   span_readback_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      wr_span ##1 (reg_rd_en && reg_addr == `DAT_SPAN_OFS && !reg_wr_en)
      |=> reg_rdata == $past(reg_wdata, 2)
   ) else $error("read-write word not read back");
endmodule

// ==== sim/dat_trim_regs_bench.sv ====
// Self-checking bench for the analog trim register bank.
// Assumes the core/ package, header and modules are compiled first.
`timescale 1ns/100ps
module dat_trim_regs_bench;
   import dat_pkg::*;
   logic clock, rst_n, wr, rd, cm, ld, cl, ren;
   dat_addr_type a;
   dat_word_type wd, rdat;
   dat_gain_type cg, fg, mg;
   dat_rset_type cr, rc, mr;
   dat_ref_trim_type rt;
   dat_span_type sp;
   dat_word_type m [5];
   int bad_count, num_checks, i;
   localparam dat_addr_type adr [6] = '{8'h03, 8'h07, 8'h08, 8'h0c, 8'h00, 8'h1c};
   localparam logic [23:0] cor [7] = '{24'h030020, 24'h03001f, 24'h07ff40, 24'h07003f,
      24'h0cffff, 24'h0c0005, 24'h0c6014};
   dat_trim_regs uut (.clock(clock), .rst_n(rst_n), .reg_addr(a), .reg_wr_en(wr),
      .reg_rd_en(rd), .reg_wdata(wd), .reg_rdata(rdat), .cal_mode_en(cm),
      .cal_result_load(ld), .cal_result_clear(cl), .cal_gain_value(cg),
      .cal_rset_value(cr), .reference_trim_code(rt), .applied_fine_gain(fg),
      .gain_span_select(sp), .internal_resistor_enable(ren), .full_scale_resistor_code(rc));
   ////////////////////////////////////////////////////////////////
   function automatic int idx(dat_addr_type x);
      case (x)
         8'h03: return 0;
         8'h07: return 1;
         8'h08: return 2;
         8'h0c: return 3;
         default: return 4;
      endcase
   endfunction
   function automatic dat_word_type exp_rd(dat_addr_type x);
      case (idx(x))
         0: return m[0];
         1: return {m[1][15], mg, m[1][7:0]};
         2: return m[2];
         3: return {cm, m[3][14:13], mr, m[3][7:0]};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_t(dat_addr_type x, dat_word_type d);
      @(posedge clock);
      wr <= 1'b1;
      a <= x;
      wd <= d;
      @(posedge clock);
      wr <= 1'b0;
      m[idx(x)] = d;
   endtask
   task automatic rd_t(dat_addr_type x);
      @(posedge clock);
      rd <= 1'b1;
      a <= x;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk("reg_rdata", exp_rd(x), rdat);
   endtask
   task automatic wr_rd_t(dat_addr_type x, dat_word_type d);
      @(posedge clock);
      wr <= 1'b1;
      a <= x;
      wd <= d;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b1;
      m[idx(x)] = d;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk("reg_rdata", exp_rd(x), rdat);
   endtask
   task automatic chk_out;
      @(posedge clock);
      #1;
      chk("ref_trim", 16'(m[0][5:0]), 16'(rt));
      chk("fine_gain", {9'h000, (cm ? mg : m[1][6:0])}, {9'h000, fg});
      chk("span", 16'(m[2][1:0]), 16'(sp));
      chk("rset_en", 16'(cm | m[3][15]), 16'(ren));
      chk("rset_code", 16'(cm ? mr : m[3][4:0]), 16'(rc));
   endtask
   task automatic cal_t(logic l, logic c, dat_gain_type g, dat_rset_type r);
      @(posedge clock);
      ld <= l;
      cl <= c;
      cg <= g;
      cr <= r;
      @(posedge clock);
      ld <= 1'b0;
      cl <= 1'b0;
      cg <= ~g;
      cr <= ~r;
      mg = l ? g : (c ? 7'h00 : mg);
      mr = l ? r : (c ? 5'h00 : mr);
   endtask
   task automatic set_cm(logic v);
      @(posedge clock);
      cm <= v;
      @(posedge clock);
   endtask
   task automatic rst_t(int n);
      @(posedge clock);
      rst_n <= 1'b0;
      cm <= 1'b0;
      m = '{16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000};
      mg = 7'h00;
      mr = 5'h00;
      repeat (n) @(posedge clock);
      rst_n <= 1'b1;
      foreach (adr[j]) rd_t(adr[j]);
      chk_out();
      $display("test reset done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      {rst_n, wr, rd, cm, ld, cl, a, wd, cg, cr} = '0;
      bad_count = 0;
      num_checks = 0;
      void'($urandom(32'h38571347));
      rst_t(12);
      foreach (cor[j]) begin
         wr_t(cor[j][23:16], cor[j][15:0]);
         rd_t(cor[j][23:16]);
         chk_out();
      end
      for (i = 0; i < 4; i++) begin
         wr_t(8'h08, 16'(i));
         chk_out();
      end
      wr_t(8'h1c, 16'h1234);
      rd_t(8'h1c);
      for (i = 0; i < 4; i++) begin
         wr_rd_t(adr[i], 16'($urandom));
         chk_out();
      end
      $display("test corners done");
      cal_t(1'b1, 1'b1, 7'h45, 5'h13);
      rd_t(8'h07);
      rd_t(8'h0c);
      set_cm(1'b1);
      chk_out();
      rd_t(8'h0c);
      cal_t(1'b0, 1'b1, 7'h2a, 5'h0e);
      chk_out();
      set_cm(1'b0);
      chk_out();
      $display("test calibration done");
      for (i = 0; i < 300; i++) begin
         case ($urandom_range(0, 3))
            0: wr_t(adr[$urandom_range(0, 5)], 16'($urandom));
            1: rd_t(adr[$urandom_range(0, 5)]);
            2: cal_t(1'($urandom), 1'($urandom), 7'($urandom), 5'($urandom));
            default: set_cm(1'($urandom));
         endcase
         chk_out();
      end
      $display("test random done");
      rst_t(2);
      results();
   end
endmodule
